//--- fbp_pkg.sv
// package: shared constants and types of the flash sequencer
package fbp_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_ADDR_LO = 4'h1;
  localparam logic [3:0] OFS_ADDR_HI = 4'h2;
  localparam logic [3:0] OFS_DATA = 4'h3;
  localparam logic [3:0] OFS_STATE = 4'h4;
  localparam logic [3:0] OFS_PROT = 4'h5;
  // ----------------------------------------
  // flash_state_reg fields
  // ----------------------------------------
  localparam int BIT_CBEF = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_VIOL = 5;
  localparam int BIT_ACCERR = 4;
  localparam int BIT_PUMP = 0;
  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  // ----------------------------------------
  // protection layout
  // ----------------------------------------
  localparam int BIT_PDIS = 0;
  localparam logic [8:0] PROT_LOW_ONES = 9'h1FF;
  localparam logic [5:0] ROW_START = 6'h00;
  localparam logic [7:0] PROT_RESET = 8'hFF;
  // ----------------------------------------
  // timing: clock periods in ns, divider in system clocks, durations in flash clock periods
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int FCLK_PERIOD_NS = 5000;
  localparam int CLK_DIV_DEF =
    (FCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [14:0] TICKS_BLANK = 15'h0001;
  localparam logic [14:0] TICKS_BYTE = 15'h0009;
  localparam logic [14:0] TICKS_BURST = 15'h0004;
  localparam int TICKS_PAGE_DEF = 4000;
  localparam int TICKS_MASS_DEF = 20000;
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic {ST_IDLE, ST_RUN} fbp_fsm_type;
  typedef struct packed {
    logic [7:0] cmd_stage;
    logic [15:0] addr_stage;
    logic [7:0] data_stage;
    logic qv;
    logic [7:0] q_cmd;
    logic [15:0] q_addr;
    logic [7:0] q_data;
    fbp_fsm_type st;
    logic [7:0] a_cmd;
    logic [15:0] a_addr;
    logic [15:0] div_cnt;
    logic [14:0] tick_cnt;
    logic pump;
    logic start;
    logic cont;
    logic [15:0] out_addr;
    logic [7:0] out_data;
    logic cbef;
    logic viol;
    logic accerr;
    logic [7:0] prot;
    logic loaded;
    logic [7:0] rdata;
  } fbp_state_type;
endpackage

//--- fbp_flash_seq.sv
// module: flash command sequencer with burst and block protection
// Functional notes
// - ordinary program/erase raises pump at start, drops it at end.
// - burst program keeps pump on past the byte when continuing.
// - pump stays on only if next burst is queued before finish.
// - rows are 64 bytes by A5..A0; continue only within a row.
// - first burst byte uses the standard byte program time.
// - continued burst bytes use the shorter burst time.
// - new row drops and re-raises pump, standard time.
// - nothing queued at finish: pump off, high voltage removed.
// - program/erase into protected top region is refused.
// - protection register loads from nonvolatile byte after reset.
// - software writes to the protection register are ignored.
// - debug port writes to the protection register are accepted.
// - last unprotected address is boundary bits then nine ones.
// - protection active only when disable bit 0 is zero.
// - protection byte lies in protected top, so software cannot alter it.
module fbp_flash_seq #(
  parameter int CLK_DIV = fbp_pkg::CLK_DIV_DEF,
  parameter int TICKS_PAGE = fbp_pkg::TICKS_PAGE_DEF,
  parameter int TICKS_MASS = fbp_pkg::TICKS_MASS_DEF
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic we_in,
  input wire logic re_in,
  output logic [7:0] rdata_out,
  input wire logic [7:0] nv_protect_byte_in,
  input wire logic dbg_prot_we_in,
  input wire logic [7:0] dbg_prot_data_in,
  output logic hv_pump_en_out,
  output logic array_start_out,
  output logic [7:0] array_cmd_out,
  output logic [15:0] array_addr_out,
  output logic [7:0] array_data_out
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // counters are 16 and 15 bits wide, larger values cannot be timed
  if (CLK_DIV < 1 || CLK_DIV > 65535) begin : g_bad_div
    $error("CLK_DIV out of range");
  end
  if (TICKS_PAGE < 1 || TICKS_PAGE > 32767) begin : g_bad_page
    $error("TICKS_PAGE out of range");
  end
  if (TICKS_MASS < 1 || TICKS_MASS > 32767) begin : g_bad_mass
    $error("TICKS_MASS out of range");
  end

  localparam logic [15:0] DIV_LAST = 16'(CLK_DIV - 1);
  localparam logic [14:0] T_PAGE = 15'(TICKS_PAGE);
  localparam logic [14:0] T_MASS = 15'(TICKS_MASS);

  fbp_pkg::fbp_state_type q, d;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // address above the last unprotected one while enabled
  function automatic logic is_prot(input logic [7:0] p,
                                   input logic [15:0] a);
    is_prot = !p[fbp_pkg::BIT_PDIS] &&
      (a > {p[7:1], fbp_pkg::PROT_LOW_ONES});
  endfunction

  function automatic logic is_valid(input logic [7:0] c);
    is_valid = (c == fbp_pkg::CMD_BLANK) ||
      (c == fbp_pkg::CMD_BYTE) || (c == fbp_pkg::CMD_BURST) ||
      (c == fbp_pkg::CMD_PAGE) || (c == fbp_pkg::CMD_MASS);
  endfunction

  function automatic logic [14:0] dur(input logic [7:0] c,
                                      input logic burst);
    case (c)
      fbp_pkg::CMD_BLANK: dur = fbp_pkg::TICKS_BLANK;
      fbp_pkg::CMD_PAGE: dur = T_PAGE;
      fbp_pkg::CMD_MASS: dur = T_MASS;
      default: dur = burst ? fbp_pkg::TICKS_BURST
                           : fbp_pkg::TICKS_BYTE;
    endcase
  endfunction

  // takes the queued command; refused ones never reach the array
  function automatic fbp_pkg::fbp_state_type take(
      input fbp_pkg::fbp_state_type s, input logic burst);
    take = s;
    take.qv = 1'b0;
    take.cbef = 1'b1;
    if (!is_valid(s.q_cmd)) begin
      take.accerr = 1'b1;
    end else if (s.q_cmd != fbp_pkg::CMD_BLANK &&
      ((s.q_cmd == fbp_pkg::CMD_MASS && !s.prot[0]) ||
       is_prot(s.prot, s.q_addr))) begin
      take.viol = 1'b1;
    end else begin
      take.st = fbp_pkg::ST_RUN;
      take.a_cmd = s.q_cmd;
      take.a_addr = s.q_addr;
      take.out_addr = s.q_addr;
      take.out_data = s.q_data;
      take.start = 1'b1;
      take.cont = burst;
      take.pump = (s.q_cmd != fbp_pkg::CMD_BLANK);
      take.div_cnt = '0;
      take.tick_cnt = dur(s.q_cmd, burst);
    end
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic tick;
  logic [15:0] next_addr;
  logic chain;

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.cont = 1'b0;
    d.rdata = 8'h00;
    tick = (q.div_cnt == DIV_LAST);
    next_addr = q.a_addr + 16'h0001;
    // continuation: queued burst, sequential, same row
    chain = (q.a_cmd == fbp_pkg::CMD_BURST) && q.qv &&
      (q.q_cmd == fbp_pkg::CMD_BURST) &&
      (q.q_addr == next_addr) &&
      (next_addr[5:0] != fbp_pkg::ROW_START) &&
      !is_prot(q.prot, q.q_addr);
    // strap-like load, once after reset release
    if (!q.loaded) begin
      d.prot = nv_protect_byte_in;
      d.loaded = 1'b1;
    end
    if (dbg_prot_we_in) begin
      d.prot = dbg_prot_data_in;
    end
    // sequencer
    case (q.st)
      fbp_pkg::ST_IDLE: begin
        if (q.qv) begin
          d = take(d, 1'b0);
        end
      end
      fbp_pkg::ST_RUN: begin
        d.div_cnt = tick ? 16'h0000 : q.div_cnt + 16'h0001;
        if (tick) begin
          d.tick_cnt = q.tick_cnt - 15'h0001;
          if (q.tick_cnt == 15'h0001) begin
            if (chain) begin
              d = take(d, 1'b1);
            end else begin
              // one idle cycle with pump off before next op
              d.pump = 1'b0;
              d.st = fbp_pkg::ST_IDLE;
            end
          end
        end
      end
      default: d.st = fbp_pkg::ST_IDLE;
    endcase
    // bus writes; a launch only happens with the queue empty
    if (we_in) begin
      case (addr_in)
        fbp_pkg::OFS_CMD: d.cmd_stage = wdata_in;
        fbp_pkg::OFS_ADDR_LO: d.addr_stage[7:0] = wdata_in;
        fbp_pkg::OFS_ADDR_HI: d.addr_stage[15:8] = wdata_in;
        fbp_pkg::OFS_DATA: d.data_stage = wdata_in;
        fbp_pkg::OFS_STATE: begin
          if (wdata_in[fbp_pkg::BIT_CBEF] && q.cbef) begin
            d.qv = 1'b1;
            d.q_cmd = q.cmd_stage;
            d.q_addr = q.addr_stage;
            d.q_data = q.data_stage;
            d.cbef = 1'b0;
          end
          // set wins over clear only if the flag was clear before
          if (wdata_in[fbp_pkg::BIT_VIOL] && !(d.viol && !q.viol))
            d.viol = 1'b0;
          if (wdata_in[fbp_pkg::BIT_ACCERR] &&
              !(d.accerr && !q.accerr))
            d.accerr = 1'b0;
        end
        fbp_pkg::OFS_PROT: ;
        default: ;
      endcase
    end
    // read data valid the cycle after the strobe only
    if (re_in) begin
      case (addr_in)
        fbp_pkg::OFS_CMD: d.rdata = q.cmd_stage;
        fbp_pkg::OFS_ADDR_LO: d.rdata = q.addr_stage[7:0];
        fbp_pkg::OFS_ADDR_HI: d.rdata = q.addr_stage[15:8];
        fbp_pkg::OFS_DATA: d.rdata = q.data_stage;
        fbp_pkg::OFS_STATE: begin
          d.rdata[fbp_pkg::BIT_CBEF] = q.cbef;
          d.rdata[fbp_pkg::BIT_BUSY] = (q.st == fbp_pkg::ST_RUN);
          d.rdata[fbp_pkg::BIT_VIOL] = q.viol;
          d.rdata[fbp_pkg::BIT_ACCERR] = q.accerr;
          d.rdata[fbp_pkg::BIT_PUMP] = q.pump;
        end
        fbp_pkg::OFS_PROT: d.rdata = q.prot;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
      q.st <= fbp_pkg::ST_IDLE;
      q.cbef <= 1'b1;
      q.prot <= fbp_pkg::PROT_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rdata_out = q.rdata;
  assign hv_pump_en_out = q.pump;
  assign array_start_out = q.start;
  assign array_cmd_out = q.a_cmd;
  assign array_addr_out = q.out_addr;
  assign array_data_out = q.out_data;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_pump_at_start: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    q.start && q.a_cmd != fbp_pkg::CMD_BLANK |-> q.pump)
    else $error("pump not on at op start");

  a_pump_off_end: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    q.st == fbp_pkg::ST_RUN ##1 q.st == fbp_pkg::ST_IDLE
    |-> !q.pump)
    else $error("pump left on after op");

  a_burst_keeps_pump: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    q.cont |-> q.pump && $past(q.pump) &&
      $past(q.st) == fbp_pkg::ST_RUN)
    else $error("pump dropped inside burst");

  a_row_break: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    q.cont |-> q.out_addr[5:0] != fbp_pkg::ROW_START &&
      q.out_addr == $past(q.a_addr) + 16'h0001)
    else $error("burst continued across row");

  a_first_std_time: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    q.start && !q.cont && q.a_cmd == fbp_pkg::CMD_BURST
    |-> q.tick_cnt == fbp_pkg::TICKS_BYTE)
    else $error("first burst byte not standard time");

  a_burst_time: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    q.cont |-> q.tick_cnt == fbp_pkg::TICKS_BURST)
    else $error("continued byte not burst time");

  a_prot_block: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    q.start && q.a_cmd != fbp_pkg::CMD_BLANK
    |-> !is_prot(q.prot, q.out_addr) &&
      (q.a_cmd != fbp_pkg::CMD_MASS || q.prot[0]))
    else $error("op started in protected region");

  a_nv_load: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    $rose(q.loaded) && !$past(dbg_prot_we_in)
    |-> q.prot == $past(nv_protect_byte_in))
    else $error("protection not loaded from nv byte");

  a_sw_no_prot: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    q.loaded && !dbg_prot_we_in |=> $stable(q.prot))
    else $error("protection changed without debug");

  a_dbg_write: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    dbg_prot_we_in |=> q.prot == $past(dbg_prot_data_in))
    else $error("debug write to protection lost");

  a_viol_no_op: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    $rose(q.viol) |-> !q.start)
    else $error("refused command reached array");

  a_cont_queued: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    q.cont |-> $past(q.qv) && $past(q.q_cmd) == fbp_pkg::CMD_BURST)
    else $error("burst continued without queued command");

  a_new_row_std: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    q.start && q.a_cmd == fbp_pkg::CMD_BURST &&
      q.out_addr[5:0] == fbp_pkg::ROW_START
    |-> !q.cont && !$past(q.pump) && q.tick_cnt == fbp_pkg::TICKS_BYTE)
    else $error("new row byte kept pump or burst time");
endmodule

//--- fbp_host.sv
// host model: register bus master and debug port driver
module fbp_host (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [3:0] addr_out,
  output logic [7:0] wdata_out,
  output logic we_out,
  output logic re_out,
  output logic dbg_we_out,
  output logic [7:0] dbg_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bus cycles, all launched right after a rising edge
  // ----------------------------------------
  initial begin
    addr_out = 4'h0;
    wdata_out = 8'h00;
    we_out = 1'b0;
    re_out = 1'b0;
    dbg_we_out = 1'b0;
    dbg_data_out = 8'h00;
  end
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    we_out <= 1'b1;
    @(posedge clk_in);
    we_out <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    re_out <= 1'b1;
    @(posedge clk_in);
    re_out <= 1'b0;
    #1 d = rdata_in;
  endtask
  // writing one to the empty flag starts the queued command
  task automatic launch();
    wr(fbp_pkg::OFS_STATE, 8'h80);
  endtask
  // background debug path bypasses the software lock
  task automatic dbg(input logic [7:0] d);
    @(posedge clk_in);
    dbg_data_out <= d;
    dbg_we_out <= 1'b1;
    @(posedge clk_in);
    dbg_we_out <= 1'b0;
  endtask
endmodule

//--- tb_flash_burst_and_protection.sv
// testbench: burst timing, pump control and block protection
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin \
  err_count++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_flash_burst_and_protection;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;
  typedef struct {
    logic [7:0] c;
    logic [15:0] a;
    logic [7:0] d;
    logic dr;
    int g;
  } fbp_note_type;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, nv, dbg_d, a_cmd, a_data;
  logic we, re, dbg_we, pump, start, low_seen = 1'b1;
  logic [15:0] a_addr;
  int err_count = 0, check_count = 0, gap_cnt = 0, seed = 39920;
  fbp_note_type exp_q[$];
  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  initial forever #2 clk_sys_in = ~clk_sys_in;
  fbp_flash_seq #(.CLK_DIV(DIV), .TICKS_PAGE(5), .TICKS_MASS(6)) i_dut (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .addr_in(addr),
    .wdata_in(wdata), .we_in(we), .re_in(re), .rdata_out(rdata),
    .nv_protect_byte_in(nv), .dbg_prot_we_in(dbg_we),
    .dbg_prot_data_in(dbg_d), .hv_pump_en_out(pump),
    .array_start_out(start), .array_cmd_out(a_cmd),
    .array_addr_out(a_addr), .array_data_out(a_data));
  fbp_host i_host (.clk_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .we_out(we), .re_out(re), .dbg_we_out(dbg_we),
    .dbg_data_out(dbg_d));
  // watcher: each start pulse consumes the oldest note
  always @(posedge clk_sys_in) begin
    fbp_note_type n;
    gap_cnt <= gap_cnt + 1;
    if (pump !== 1'b1) low_seen <= 1'b1;
    if (start === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK("unexpected start", 1'b0, 1'b1)
      end else begin
        n = exp_q.pop_front();
        `CHK("cmd", n.c, a_cmd)
        `CHK("addr", n.a, a_addr)
        `CHK("data", n.d, a_data)
        `CHK("pump dropped", n.dr, low_seen)
        if (!n.dr) `CHK("gap", n.g, gap_cnt)
      end
      low_seen <= 1'b0;
      gap_cnt <= 1;
    end
  end
  // ----------------------------------------
  // stimulus helpers
  // ----------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    logic [7:0] v;
    i_host.rd(a, v);
    `CHK("reg read", e, v & m)
  endtask
  // stage a command, launch once the buffer is free, note the result
  task automatic prog(input logic [7:0] c, input logic [15:0] a,
                      input logic ok, input logic dr, input int g);
    logic [7:0] s, d;
    d = 8'($random(seed));
    i_host.wr(fbp_pkg::OFS_ADDR_LO, a[7:0]);
    i_host.wr(fbp_pkg::OFS_ADDR_HI, a[15:8]);
    i_host.wr(fbp_pkg::OFS_DATA, d);
    i_host.wr(fbp_pkg::OFS_CMD, c);
    for (int i = 0; i < 400; i++) begin
      i_host.rd(fbp_pkg::OFS_STATE, s);
      if (s[fbp_pkg::BIT_CBEF] === 1'b1) begin
        if (ok) exp_q.push_back('{c, a, d, dr, g});
        i_host.launch();
        return;
      end
    end
    err_count++;
    results();
  endtask
  // idle means buffer empty and not busy; pump must then be off
  task automatic wait_idle();
    logic [7:0] s;
    for (int i = 0; i < 400; i++) begin
      i_host.rd(fbp_pkg::OFS_STATE, s);
      if (s[7:6] === 2'b10) begin
        `CHK("pump off", 1'b0, pump)
        return;
      end
    end
    err_count++;
    results();
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nv = 8'hF8;
    repeat (6) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rchk(fbp_pkg::OFS_PROT, 8'hFF, 8'hF8);
    i_host.wr(fbp_pkg::OFS_PROT, 8'h00);
    rchk(fbp_pkg::OFS_PROT, 8'hFF, 8'hF8);
    prog(8'h20, 16'h1000, 1, 1, 0);
    prog(8'h20, 16'h1001, 1, 1, 0);
    wait_idle();
    // burst crossing into a new row; later bytes queued early
    prog(8'h25, 16'h103D, 1, 1, 0);
    prog(8'h25, 16'h103E, 1, 0, 9 * DIV);
    prog(8'h25, 16'h103F, 1, 0, 4 * DIV);
    prog(8'h25, 16'h1040, 1, 1, 0);
    wait_idle();
    prog(8'h40, 16'h2000, 1, 1, 0);
    wait_idle();
    prog(8'h05, 16'h2000, 1, 1, 0);
    wait_idle();
    // undefined code: no start, access error stands until cleared
    prog(8'h33, 16'h3000, 0, 1, 0);
    wait_idle();
    rchk(fbp_pkg::OFS_STATE, 8'h10, 8'h10);
    i_host.wr(fbp_pkg::OFS_STATE, 8'h10);
    rchk(fbp_pkg::OFS_STATE, 8'h10, 8'h00);
    // protected top above the last unprotected address
    prog(8'h20, 16'hFA00, 0, 1, 0);
    wait_idle();
    rchk(fbp_pkg::OFS_STATE, 8'h20, 8'h20);
    i_host.wr(fbp_pkg::OFS_STATE, 8'h20);
    rchk(fbp_pkg::OFS_STATE, 8'h20, 8'h00);
    prog(8'h20, 16'hF9FF, 1, 1, 0);
    prog(8'h41, 16'h0000, 0, 1, 0);
    prog(8'h20, 16'hFFFF, 0, 1, 0);
    wait_idle();
    i_host.dbg(8'hFF);
    rchk(fbp_pkg::OFS_PROT, 8'hFF, 8'hFF);
    prog(8'h20, 16'hFFF0, 1, 1, 0);
    prog(8'h41, 16'h0000, 1, 1, 0);
    wait_idle();
    `CHK("notes left", 0, exp_q.size())
    results();
  end
endmodule
